// ---- pkg/bbd_pkg.sv ----
package bbd_pkg;

    // Instruction field positions.
    localparam int OPC_LSB      = 0;
    localparam int OPC_W        = 6;
    localparam int DISP_LSB     = 6;
    localparam int DISP_W       = 16;
    localparam int SRC_B_LSB    = 22;
    localparam int SRC_A_LSB    = 27;
    localparam int IDX_W        = 5;
    localparam int TYPE_LSB     = 6;
    localparam int XOPC_LSB     = 11;
    localparam int DEST_LSB     = 17;

    // Encodings.
    localparam logic [5:0] OPC_BNE   = 6'h1e;
    localparam logic [5:0] OPC_JUMP  = 6'h06;
    localparam logic [5:0] OPC_RTYPE = 6'h3a;
    localparam logic [5:0] XOPC_TRAP = 6'h34;
    localparam logic [5:0] XOPC_BRET = 6'h09;
    localparam logic [4:0] TRAP_DEST = 5'h1e;

    // Status register bits.
    localparam int STAT_USER_BIT = 1;

    // Next-instruction step in bytes.
    localparam logic [31:0] PC_STEP = 32'h0000_0004;

    // Reset values.
    localparam logic [31:0] PC_RESET   = 32'h0000_0000;
    localparam logic [31:0] STAT_RESET = 32'h0000_0000;

    // Register map, byte addresses.
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_PC       = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_BSTATUS  = 8'h0c;
    localparam logic [7:0] REG_BRET     = 8'h10;
    localparam logic [7:0] REG_INSTR    = 8'h14;
    localparam logic [7:0] REG_SRC_A    = 8'h18;
    localparam logic [7:0] REG_SRC_B    = 8'h1c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h20;
    localparam logic [7:0] REG_IRQ_MASK = 8'h24;
    localparam logic [7:0] REG_TYPE     = 8'h28;

    // Event bits of status and mask.
    localparam int EV_MISALIGN = 0;
    localparam int EV_TRAP     = 1;
    localparam int EV_TAKEN    = 2;
    localparam int EV_W        = 3;

    typedef enum logic [1:0] {
        BBD_IDLE = 2'b01,
        BBD_DATA = 2'b10
    } bbd_bus_e;

endpackage : bbd_pkg

// ---- src/bbd_core.sv ----
module bbd_core
    import bbd_pkg::*;
#(
    parameter logic [31:0] TRAP_HANDLER_ADDR = 32'h0000_0020,
    parameter int          PREV_INTERRUPT_ENABLE_BIT = 0
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Interrupt.
    output logic             irq
);

    // All three checks run at elaboration, so a bad build never reaches simulation or synthesis.
    if (PREV_INTERRUPT_ENABLE_BIT < 0 || PREV_INTERRUPT_ENABLE_BIT > 31) begin : g_bad_enable_bit
        $error("bbd_core: interrupt enable bit position out of range");
    end
    if (PREV_INTERRUPT_ENABLE_BIT == STAT_USER_BIT) begin : g_enable_bit_clash
        $error("bbd_core: interrupt enable bit collides with the user bit");
    end
    if (TRAP_HANDLER_ADDR[1:0] != 2'b00) begin : g_bad_handler
        $error("bbd_core: trap handler address must be word aligned");
    end

    typedef struct packed {
        bbd_bus_e         bus;
        logic             wr;
        logic [7:0]       addr;
        logic [31:0]      rdata;
        logic [31:0]      pc;
        logic [31:0]      status;
        logic [31:0]      bstatus;
        logic [31:0]      bret;
        logic [31:0]      instr;
        logic [31:0]      src_a;
        logic [31:0]      src_b;
        logic [4:0]       trap_type;
        logic [EV_W-1:0]  ev;
        logic [EV_W-1:0]  mask;
        logic             irq;
    } bbd_state_s;

    bbd_state_s st;
    bbd_state_s next_st;

    // Decode of the instruction held in the instruction register.
    logic [5:0]  opc;
    logic [5:0]  xopc;
    logic [4:0]  idx_a;
    logic [4:0]  idx_b;
    logic [4:0]  dest;
    logic [15:0] branch_displacement;
    logic [31:0] disp_ext;
    logic [31:0] pc_next_seq;
    logic [31:0] target;
    logic        is_bne;
    logic        is_jump;
    logic        is_trap;
    logic        is_bret;

    always_comb begin
        opc                 = st.instr[OPC_LSB +: OPC_W];
        xopc                = st.instr[XOPC_LSB +: OPC_W];
        idx_a               = st.instr[SRC_A_LSB +: IDX_W];
        idx_b               = st.instr[SRC_B_LSB +: IDX_W];
        dest                = st.instr[DEST_LSB +: IDX_W];
        branch_displacement = st.instr[DISP_LSB +: DISP_W];
        disp_ext            = {{16{branch_displacement[15]}}, branch_displacement};
        pc_next_seq         = st.pc + PC_STEP;
        target              = pc_next_seq + disp_ext;
        is_bne              = (opc == OPC_BNE);
        is_jump             = (opc == OPC_JUMP) && (idx_a == 5'h00) && (idx_b == 5'h00);
        // The type field sits outside the match so every type traps alike.
        is_trap             = (opc == OPC_RTYPE) && (xopc == XOPC_TRAP) && (dest == TRAP_DEST)
                              && (idx_a == 5'h00) && (idx_b == 5'h00);
        // The return names the saved-return register as its first operand, second operand and destination zero.
        is_bret             = (opc == OPC_RTYPE) && (xopc == XOPC_BRET) && (dest == 5'h00)
                              && (idx_a == TRAP_DEST) && (idx_b == 5'h00);
    end

    logic [7:0]       a_addr;
    logic             exec;
    logic [EV_W-1:0]  ev_set;
    logic [EV_W-1:0]  ev_clr;
    logic [31:0]      new_pc;

    always_comb begin
        next_st   = st;
        a_addr    = haddr[7:0];
        exec      = 1'b0;
        ev_set    = '0;
        ev_clr    = '0;
        new_pc    = pc_next_seq;
        next_st.bus = BBD_IDLE;

        // Data phase of a previous write.
        if (st.bus == BBD_DATA && st.wr) begin
            case (st.addr)
                REG_PC: begin
                    next_st.pc = hwdata;
                end
                REG_STATUS: begin
                    next_st.status = hwdata;
                end
                REG_BSTATUS: begin
                    next_st.bstatus = hwdata;
                end
                REG_BRET: begin
                    next_st.bret = hwdata;
                end
                REG_INSTR: begin
                    next_st.instr = hwdata;
                end
                REG_SRC_A: begin
                    next_st.src_a = hwdata;
                end
                REG_SRC_B: begin
                    next_st.src_b = hwdata;
                end
                REG_IRQ_MASK: begin
                    next_st.mask = hwdata[EV_W-1:0];
                end
                REG_IRQ_STAT: begin
                    ev_clr = hwdata[EV_W-1:0];
                end
                REG_CTRL: begin
                    exec = hwdata[0];
                end
                default: begin
                    exec = 1'b0;
                end
            endcase
        end

        // One execution step. A write of the control register with bit 0 set retires the held word;
        // all state changes of one instruction happen in the same edge, so the trap is exact.
        if (exec) begin
            if (is_bne) begin
                if (st.src_a != st.src_b) begin
                    new_pc    = target;
                    ev_set[EV_TAKEN] = 1'b1;
                end
            end else if (is_jump) begin
                new_pc = target;
                ev_set[EV_TAKEN] = 1'b1;
            end else if (is_trap) begin
                next_st.bstatus = st.status;
                next_st.status  = st.status;
                next_st.status[PREV_INTERRUPT_ENABLE_BIT] = 1'b0;
                next_st.status[STAT_USER_BIT] = 1'b0;
                next_st.bret      = pc_next_seq;
                next_st.trap_type = st.instr[TYPE_LSB +: IDX_W];
                new_pc            = TRAP_HANDLER_ADDR;
                ev_set[EV_TRAP]   = 1'b1;
            end else if (is_bret) begin
                next_st.status = st.bstatus;
                new_pc         = st.bret;
            end
            // A misaligned target leaves the pc untouched and flags the fault.
            if (new_pc[1:0] != 2'b00) begin
                ev_set[EV_MISALIGN] = 1'b1;
                ev_set[EV_TAKEN]    = 1'b0;
            end else begin
                next_st.pc = new_pc;
            end
        end

        // Set wins over a simultaneous write-one clear.
        next_st.ev  = (st.ev & ~ev_clr) | ev_set;
        next_st.irq = |(next_st.ev & next_st.mask);

        // Address phase; zero wait states.
        if (hsel && hready && htrans[1]) begin
            next_st.bus  = BBD_DATA;
            next_st.wr   = hwrite;
            next_st.addr = a_addr;
            if (!hwrite) begin
                case (a_addr)
                    REG_CTRL:     next_st.rdata = 32'h0000_0000;
                    REG_PC:       next_st.rdata = next_st.pc;
                    REG_STATUS:   next_st.rdata = next_st.status;
                    REG_BSTATUS:  next_st.rdata = next_st.bstatus;
                    REG_BRET:     next_st.rdata = next_st.bret;
                    REG_INSTR:    next_st.rdata = next_st.instr;
                    REG_SRC_A:    next_st.rdata = next_st.src_a;
                    REG_SRC_B:    next_st.rdata = next_st.src_b;
                    REG_IRQ_STAT: next_st.rdata = {{(32-EV_W){1'b0}}, next_st.ev};
                    REG_IRQ_MASK: next_st.rdata = {{(32-EV_W){1'b0}}, next_st.mask};
                    REG_TYPE:     next_st.rdata = {27'h0000000, next_st.trap_type};
                    default:      next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st.bus       <= BBD_IDLE;
            st.wr        <= 1'b0;
            st.addr      <= 8'h00;
            st.rdata     <= 32'h0000_0000;
            st.pc        <= PC_RESET;
            st.status    <= STAT_RESET;
            st.bstatus   <= STAT_RESET;
            st.bret      <= 32'h0000_0000;
            st.instr     <= 32'h0000_0000;
            st.src_a     <= 32'h0000_0000;
            st.src_b     <= 32'h0000_0000;
            st.trap_type <= 5'h00;
            st.ev        <= '0;
            st.mask      <= '0;
            st.irq       <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Read data and irq from flops; the slave never stalls and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;
    assign irq       = st.irq;

endmodule : bbd_core

// ---- verification/bbd_core_sva.sv ----
module bbd_core_sva
    import bbd_pkg::*;
(
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus.
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        irq
);
    logic            acc;
    logic            ap_rd;
    logic            ap_wr;
    logic [7:0]      ap_a;
    logic [EV_W-1:0] mask_sh;
    assign acc = hsel && hready && htrans[1];
    // Shadow of the mask, so irq can be judged without seeing inside.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_rd   <= 1'b0;
            ap_wr   <= 1'b0;
            ap_a    <= 8'h00;
            mask_sh <= '0;
        end else begin
            ap_rd <= acc && !hwrite;
            ap_wr <= acc && hwrite;
            ap_a  <= haddr[7:0];
            if (ap_wr && ap_a == REG_IRQ_MASK) begin
                mask_sh <= hwdata[EV_W-1:0];
            end
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_always_a: assert property (hreadyout) else $error("slave inserted a wait");
    resp_okay_a: assert property (!hresp) else $error("slave answered with an error");
    ctrl_reads_zero_a: assert property (ap_rd && ap_a == REG_CTRL |-> hrdata == 32'h0) else $error("ctrl read not 0");
    unmapped_zero_a: assert property (ap_rd && ap_a > REG_TYPE |-> hrdata == 32'h0) else $error("unmapped read not 0");
    rdata_hold_a: assert property (!(acc && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
    type_width_a: assert property (ap_rd && ap_a == REG_TYPE |-> hrdata[31:5] == 27'h0) else $error("type too wide");
    stat_width_a: assert property (ap_rd && ap_a == REG_IRQ_STAT |-> hrdata[31:EV_W] == '0) else $error("stray bits");
    irq_masked_a: assert property (mask_sh == '0 && $past(mask_sh) == '0 |-> !irq) else $error("masked irq rose");
endmodule : bbd_core_sva

bind bbd_core bbd_core_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));

// ---- verification/branch_and_breakpoint_decode_bench.sv ----
module branch_and_breakpoint_decode_bench
    import bbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] HANDLER = 32'h0000_0400;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        irq;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cyc = 0;
    always #10 hclk = ~hclk;
    bbd_core #(.TRAP_HANDLER_ADDR(HANDLER), .PREV_INTERRUPT_ENABLE_BIT(0)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk
    // The answer is awaited, never assumed; the timeout cuts a hang.
    task automatic xfer(input logic wnr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        haddr <= {24'h0, a};
        hwrite <= wnr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask : rd
    task automatic run(input logic [31:0] pc, input logic [31:0] ins, input logic [31:0] va, input logic [31:0] vb);
        wr(REG_PC, pc);
        wr(REG_INSTR, ins);
        wr(REG_SRC_A, va);
        wr(REG_SRC_B, vb);
        wr(REG_CTRL, 32'h1);
    endtask : run
    task automatic t_reset;
        logic [7:0] regs [8] = '{REG_PC, REG_STATUS, REG_BSTATUS, REG_BRET, REG_IRQ_STAT, REG_IRQ_MASK, REG_TYPE, 8'h30};
        wr(8'h30, 32'hffff_ffff);
        foreach (regs[i]) rd("reset value", regs[i], 32'h0);
    endtask : t_reset
    // Branch table: pc, displacement, operands, opcode, expected pc.
    task automatic t_branch;
        logic [31:0] pc [5] = '{32'h100, 32'h100, 32'h1000, 32'h8000, 32'h200};
        logic [15:0] dp [5] = '{16'hfff0, 16'hfff0, 16'h7ffc, 16'h8000, 16'h0008};
        logic [31:0] va [5] = '{5, 9, 0, 1, 3};
        logic [31:0] ex [5] = '{32'hf4, 32'h104, 32'h9000, 32'h4, 32'h20c};
        logic [4:0]  ix;
        for (int i = 0; i < 5; i++) begin
            ix = (i == 4) ? 5'h0 : 5'h6;
            run(pc[i], {ix, ix + (i == 4 ? 5'h0 : 5'h1), dp[i], i == 4 ? OPC_JUMP : OPC_BNE}, va[i], i == 1 ? 9 : 3);
            rd("next pc", REG_PC, ex[i]);
        end
    endtask : t_branch
    task automatic t_misalign;
        wr(REG_IRQ_STAT, 32'h7);
        run(32'h40, {5'h6, 5'h7, 16'h0002, OPC_BNE}, 1, 2);
        rd("pc kept", REG_PC, 32'h40);
        rd("fault event", REG_IRQ_STAT, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(REG_IRQ_MASK, 32'h1);
        rd("mask", REG_IRQ_MASK, 32'h1);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(REG_IRQ_STAT, 32'h1);
        rd("cleared", REG_IRQ_STAT, 32'h0);
        chk("irq dropped", 32'h0, {31'h0, irq});
    endtask : t_misalign
    task automatic t_trap;
        for (int i = 0; i < 2; i++) begin
            wr(REG_STATUS, 32'h7);
            run(32'h300, {10'h0, TRAP_DEST, XOPC_TRAP, i ? 5'h00 : 5'h1f, OPC_RTYPE}, 1, 2);
            rd("handler", REG_PC, HANDLER);
            rd("return", REG_BRET, 32'h304);
            rd("saved", REG_BSTATUS, 32'h7);
            rd("status", REG_STATUS, 32'h4);
            rd("type", REG_TYPE, i ? 32'h0 : 32'h1f);
        end
        rd("trap event", REG_IRQ_STAT, 32'h2);
        run(32'h400, {TRAP_DEST, 5'h0, 5'h0, XOPC_BRET, 5'h0, OPC_RTYPE}, 0, 0);
        rd("resume", REG_PC, 32'h304);
        rd("restored", REG_STATUS, 32'h7);
    endtask : t_trap
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_branch();
        t_misalign();
        t_trap();
        summarize();
    end
endmodule : branch_and_breakpoint_decode_bench
